// file: rtl/fp_exc_map_pkg.sv
// Package holding operation classes, exception bit layout and attribute encodings
// Assumes the decode stage encodes each operation as one op_class_e value
package fp_exc_map_pkg;

	// ==========================================
	// Exception vector layout
	localparam int EXC_W = 6;
	localparam int EXC_INVALID = 5;
	localparam int EXC_DENORMAL = 4;
	localparam int EXC_DIV_ZERO = 3;
	localparam int EXC_OVERFLOW = 2;
	localparam int EXC_UNDERFLOW = 1;
	localparam int EXC_PRECISION = 0;

	localparam logic [5:0] EXC_NONE = 6'h00;
	localparam logic [5:0] EXC_IP = 6'h21;
	localparam logic [5:0] EXC_ID = 6'h30;
	localparam logic [5:0] EXC_NO_Z = 6'h37;
	localparam logic [5:0] EXC_ALL = 6'h3f;

	// ==========================================
	// Rounding source
	localparam logic [1:0] RND_NONE = 2'h0;
	localparam logic [1:0] RND_CSR = 2'h1;
	localparam logic [1:0] RND_TRUNC = 2'h2;

	// ==========================================
	// Operand width code: bits of source and destination transfer
	localparam logic [1:0] WID_32 = 2'h0;
	localparam logic [1:0] WID_64 = 2'h1;
	localparam logic [1:0] WID_128 = 2'h2;

	// ==========================================
	// Destination half touched by the operation
	localparam logic [1:0] HALF_FULL = 2'h0;
	localparam logic [1:0] HALF_LOW = 2'h1;
	localparam logic [1:0] HALF_HIGH = 2'h2;

	localparam int OP_W = 5;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_TRUNC_PACKED_SINGLE_TO_INT,
		OP_PACKED_INT_TO_DOUBLE,
		OP_PACKED_DOUBLE_TO_MM_INT,
		OP_PACKED_DOUBLE_TO_SINGLE,
		OP_SCALAR_DOUBLE_TO_SINGLE,
		OP_MM_INT_TO_PACKED_DOUBLE,
		OP_GPR_INT_TO_SCALAR_DOUBLE,
		OP_PACKED_SINGLE_TO_DOUBLE,
		OP_SCALAR_SINGLE_TO_DOUBLE,
		OP_SCALAR_DOUBLE_TO_GPR_INT,
		OP_TRUNC_PACKED_DOUBLE_TO_INT,
		OP_TRUNC_PACKED_DOUBLE_TO_MM_INT,
		OP_TRUNC_SCALAR_DOUBLE_TO_GPR_INT,
		OP_PACKED_DOUBLE_DIVIDE,
		OP_PACKED_DOUBLE_MAXIMUM,
		OP_SCALAR_DOUBLE_MAXIMUM,
		OP_PACKED_DOUBLE_MINIMUM,
		OP_PACKED_DOUBLE_MULTIPLY,
		OP_SCALAR_DOUBLE_MULTIPLY,
		OP_ALIGNED_VECTOR_MOVE,
		OP_UNALIGNED_VECTOR_MOVE,
		OP_HIGH_HALF_MOVE,
		OP_LOW_HALF_MOVE,
		OP_SCALAR_DOUBLE_MOVE,
		OP_SIGN_MASK_EXTRACT,
		OP_VECTOR_BITWISE_OR,
		OP_VECTOR_BITWISE_XOR,
		OP_DOUBLE_ELEMENT_SHUFFLE,
		OP_INTERLEAVE_HIGH_HALVES,
		OP_INTERLEAVE_LOW_HALVES
	} op_class_e;

	// Attributes of one operation
	typedef struct packed {
		logic known;
		logic [5:0] exc;
		logic [1:0] rnd;
		logic [1:0] src_wid;
		logic [1:0] dst_wid;
		logic [1:0] half;
	} op_attr_s;

endpackage : fp_exc_map_pkg

// file: rtl/fp_exc_lookup_if.sv
// Interface carrying one operation class in and its attributes out
// Assumes both ends sit on the same core clock
`timescale 1ns/10ps
interface fp_exc_lookup_if;
	import fp_exc_map_pkg::*;
	op_class_e op;
	op_attr_s attr;
	modport table_end (input op, output attr);
	modport user_end (output op, input attr);
endinterface : fp_exc_lookup_if

// file: rtl/fp_exc_table.sv
// Pure combinational table from operation class to exception and format attributes
// Assumes the caller registers the result
`timescale 1ns/10ps
module fp_exc_table
	import fp_exc_map_pkg::*;
(
	fp_exc_lookup_if.table_end lk
);

	// ==========================================
	// Lookup
	always_comb begin
		lk.attr = '{known: 1'b1, exc: EXC_NONE, rnd: RND_NONE, src_wid: WID_128, dst_wid: WID_128, half: HALF_FULL};
		case (lk.op)
			OP_TRUNC_PACKED_SINGLE_TO_INT: begin
				lk.attr.exc = EXC_IP; // [RULE_01]
				lk.attr.rnd = RND_TRUNC; // [RULE_01]
			end
			OP_PACKED_INT_TO_DOUBLE: begin
				lk.attr.rnd = RND_CSR; // [RULE_02]
				lk.attr.src_wid = WID_64;
			end
			OP_PACKED_DOUBLE_TO_MM_INT: begin
				lk.attr.exc = EXC_IP; // [RULE_03]
				lk.attr.rnd = RND_CSR; // [RULE_03]
				lk.attr.dst_wid = WID_64;
			end
			OP_PACKED_DOUBLE_TO_SINGLE: begin
				lk.attr.exc = EXC_NO_Z; // [RULE_04]
				lk.attr.rnd = RND_CSR;
				lk.attr.dst_wid = WID_64;
			end
			OP_SCALAR_DOUBLE_TO_SINGLE: begin
				lk.attr.exc = EXC_NO_Z; // [RULE_04]
				lk.attr.rnd = RND_CSR;
				lk.attr.src_wid = WID_64;
				lk.attr.dst_wid = WID_32;
				lk.attr.half = HALF_LOW;
			end
			OP_MM_INT_TO_PACKED_DOUBLE: begin
				lk.attr.src_wid = WID_64; // [RULE_05]
			end
			OP_GPR_INT_TO_SCALAR_DOUBLE: begin
				lk.attr.src_wid = WID_32; // [RULE_05]
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_LOW;
			end
			OP_PACKED_SINGLE_TO_DOUBLE: begin
				lk.attr.exc = EXC_ID; // [RULE_06]
				lk.attr.src_wid = WID_64;
			end
			OP_SCALAR_SINGLE_TO_DOUBLE: begin
				lk.attr.exc = EXC_ID; // [RULE_06]
				lk.attr.src_wid = WID_32;
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_LOW;
			end
			OP_SCALAR_DOUBLE_TO_GPR_INT: begin
				lk.attr.exc = EXC_IP; // [RULE_07]
				lk.attr.rnd = RND_CSR; // [RULE_07]
				lk.attr.src_wid = WID_64;
				lk.attr.dst_wid = WID_32;
			end
			OP_TRUNC_PACKED_DOUBLE_TO_INT: begin
				lk.attr.exc = EXC_IP; // [RULE_08]
				lk.attr.rnd = RND_TRUNC; // [RULE_08]
				lk.attr.dst_wid = WID_64;
			end
			OP_TRUNC_PACKED_DOUBLE_TO_MM_INT: begin
				lk.attr.exc = EXC_IP; // [RULE_08]
				lk.attr.rnd = RND_TRUNC;
				lk.attr.dst_wid = WID_64;
			end
			OP_TRUNC_SCALAR_DOUBLE_TO_GPR_INT: begin
				lk.attr.exc = EXC_IP; // [RULE_08]
				lk.attr.rnd = RND_TRUNC;
				lk.attr.src_wid = WID_64;
				lk.attr.dst_wid = WID_32;
			end
			OP_PACKED_DOUBLE_DIVIDE: begin
				lk.attr.exc = EXC_ALL; // [RULE_09]
				lk.attr.rnd = RND_CSR;
			end
			OP_PACKED_DOUBLE_MAXIMUM, OP_PACKED_DOUBLE_MINIMUM: begin
				lk.attr.exc = EXC_ID; // [RULE_10]
			end
			OP_SCALAR_DOUBLE_MAXIMUM: begin
				lk.attr.exc = EXC_ID; // [RULE_10]
				lk.attr.src_wid = WID_64;
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_LOW;
			end
			OP_PACKED_DOUBLE_MULTIPLY: begin
				lk.attr.exc = EXC_NO_Z; // [RULE_11]
				lk.attr.rnd = RND_CSR;
			end
			OP_SCALAR_DOUBLE_MULTIPLY: begin
				lk.attr.exc = EXC_NO_Z; // [RULE_11]
				lk.attr.rnd = RND_CSR;
				lk.attr.src_wid = WID_64;
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_LOW;
			end
			OP_ALIGNED_VECTOR_MOVE, OP_UNALIGNED_VECTOR_MOVE: begin
				lk.attr.exc = EXC_NONE; // [RULE_12]
			end
			OP_HIGH_HALF_MOVE: begin
				lk.attr.src_wid = WID_64; // [RULE_13]
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_HIGH; // [RULE_13]
			end
			OP_LOW_HALF_MOVE: begin
				lk.attr.src_wid = WID_64; // [RULE_13]
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_LOW; // [RULE_13]
			end
			OP_SCALAR_DOUBLE_MOVE: begin
				lk.attr.src_wid = WID_64; // [RULE_17]
				lk.attr.dst_wid = WID_64;
				lk.attr.half = HALF_LOW;
			end
			OP_VECTOR_BITWISE_OR, OP_VECTOR_BITWISE_XOR: begin
				lk.attr.exc = EXC_NONE; // [RULE_14]
			end
			OP_INTERLEAVE_HIGH_HALVES, OP_INTERLEAVE_LOW_HALVES: begin
				lk.attr.exc = EXC_NONE; // [RULE_15]
			end
			OP_SIGN_MASK_EXTRACT: begin
				lk.attr.dst_wid = WID_32; // [RULE_16]
			end
			OP_DOUBLE_ELEMENT_SHUFFLE: begin
				lk.attr.exc = EXC_NONE; // [RULE_16]
			end
			OP_NOP: begin
				lk.attr.known = 1'b1;
			end
			default: begin
				// Unmapped codes permit nothing so a bad decode cannot raise flags
				lk.attr.known = 1'b0;
			end
		endcase
	end

endmodule : fp_exc_table

// file: rtl/dp_vector_fp_exception_map.sv
// Registered exception-permission map for packed double-precision vector operations
// Assumes op_class_i and op_valid_i come from the decode stage on clk_sys_i
//
// Overview of operation
// (RULE_01) Truncating single-to-int packed: invalid, precision only
// (RULE_02) Packed int-to-double: control rounding, no exceptions
// (RULE_03) Double-to-multimedia int: control rounding, invalid, precision
// (RULE_04) Double-to-single narrowing: all except divide-by-zero
// (RULE_05) Multimedia or general int-to-double: no exceptions
// (RULE_06) Single-to-double widening: invalid and denormal only
// (RULE_07) Scalar double-to-general int: control rounding, invalid, precision
// (RULE_08) Truncating double-to-int forms: invalid, precision only
// (RULE_09) Packed divide: all six exceptions possible
// (RULE_10) Maximum and packed minimum: invalid, denormal only
// (RULE_11) Multiply: all except divide-by-zero
// (RULE_12) Full-width vector moves: no exceptions
// (RULE_13) Half moves keep other half, no exceptions
// (RULE_14) Vector OR and XOR: no exceptions
// (RULE_15) Interleave high or low halves: no exceptions
// (RULE_16) Sign mask extract and shuffle: no exceptions
// (RULE_17) Scalar double move: no exceptions
// (RULE_18) Six-bit permitted vector, invalid first, precision last
`timescale 1ns/10ps
module dp_vector_fp_exception_map
	import fp_exc_map_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input wire op_class_e op_class_i,
	output logic valid_o,
	output logic known_o,
	output logic [EXC_W-1:0] exc_allowed_o,
	output logic [1:0] round_src_o,
	output logic [1:0] src_width_o,
	output logic [1:0] dst_width_o,
	output logic [1:0] dst_half_o
);

	fp_exc_lookup_if lk ();

	// ==========================================
	// Table
	assign lk.op = op_class_i;

	fp_exc_table u_table (
		.lk(lk)
	);

	// ==========================================
	// Output stage: one cycle after op_valid_i
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_o <= 1'b0;
		end else begin
			valid_o <= op_valid_i;
		end
	end

	// Held at reset values when idle (permissions zero, widths WID_128) so downstream flag logic never sees stale permissions
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			known_o <= 1'b0;
			exc_allowed_o <= EXC_NONE;
			round_src_o <= RND_NONE;
			src_width_o <= WID_128;
			dst_width_o <= WID_128;
			dst_half_o <= HALF_FULL;
		end else if (op_valid_i) begin
			known_o <= lk.attr.known;
			exc_allowed_o <= lk.attr.known ? lk.attr.exc : EXC_NONE; // [RULE_18]
			round_src_o <= lk.attr.rnd;
			src_width_o <= lk.attr.src_wid;
			dst_width_o <= lk.attr.dst_wid;
			dst_half_o <= lk.attr.half;
		end else begin
			known_o <= 1'b0;
			exc_allowed_o <= EXC_NONE; // [RULE_18]
			round_src_o <= RND_NONE;
			src_width_o <= WID_128;
			dst_width_o <= WID_128;
			dst_half_o <= HALF_FULL;
		end
	end

endmodule : dp_vector_fp_exception_map

// file: verif/dp_vector_fp_exception_map_properties.sv
// Checker for the exception map: answer timing and permitted-exception codes
// Assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module dp_vector_fp_exception_map_properties
	import fp_exc_map_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input wire op_class_e op_class_i,
	input wire logic valid_o,
	input wire logic known_o,
	input wire logic [EXC_W-1:0] exc_allowed_o,
	input wire logic [1:0] round_src_o,
	input wire logic [1:0] src_width_o,
	input wire logic [1:0] dst_width_o,
	input wire logic [1:0] dst_half_o
);
	// ==========================================
	// Properties
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire [4:0] c = op_class_i;
	sequence s_take(int lo, int hi);
		op_valid_i && c >= lo && c <= hi;
	endsequence
	valid_lat_a: assert property (op_valid_i |=> valid_o)
		else $error("answer latency wrong");
	idle_zero_a: assert property (!op_valid_i |=> !valid_o && exc_allowed_o == EXC_NONE)
		else $error("idle output not clear");
	trunc_conv_a: assert property (
		op_valid_i && c inside {1, 11, 12, 13} |=> exc_allowed_o == EXC_IP && round_src_o == RND_TRUNC)
		else $error("truncating conversion wrong");
	narrow_mul_a: assert property (
		op_valid_i && c inside {4, 5, 18, 19} |=> exc_allowed_o == EXC_NO_Z)
		else $error("divide-by-zero permitted");
	widen_max_a: assert property (
		s_take(15, 17) or s_take(8, 9) |=> exc_allowed_o == EXC_ID)
		else $error("widen or max set wrong");
	divide_all_a: assert property (
		s_take(14, 14) ##1 !op_valid_i |-> exc_allowed_o == EXC_ALL ##1 exc_allowed_o == EXC_NONE)
		else $error("divide set wrong");
	full_move_a: assert property (
		s_take(20, 21) or s_take(26, 27) |=> src_width_o == WID_128 && dst_width_o == WID_128)
		else $error("full width wrong");
	half_move_a: assert property (
		s_take(22, 23) |=> dst_half_o == ($past(c) == 5'd22 ? HALF_HIGH : HALF_LOW))
		else $error("half select wrong");
endmodule : dp_vector_fp_exception_map_properties

bind dp_vector_fp_exception_map dp_vector_fp_exception_map_properties props_inst (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.op_valid_i(op_valid_i),
	.op_class_i(op_class_i),
	.valid_o(valid_o),
	.known_o(known_o),
	.exc_allowed_o(exc_allowed_o),
	.round_src_o(round_src_o),
	.src_width_o(src_width_o),
	.dst_width_o(dst_width_o),
	.dst_half_o(dst_half_o)
);

// file: verif/decode_stage_model.sv
// Model of the decode stage that presents operations to the exception map
// Assumes the bench changes issue_i by non-blocking assignment after a clock edge
`timescale 1ns/10ps
module decode_stage_model
	import fp_exc_map_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic issue_i,
	input wire op_class_e issue_op_i,
	output logic op_valid_o,
	output op_class_e op_class_o
);
	// ==========================================
	// Idle pattern
	// While idle the code bus steps by 3 each clock instead of holding the last operation, so a map that ignores valid shows up
	logic [4:0] idle_code = 5'h00;
	always_ff @(posedge clk_sys_i) begin
		idle_code <= idle_code + 5'h03;
	end
	assign op_valid_o = issue_i;
	assign op_class_o = issue_i ? issue_op_i : op_class_e'(idle_code);
endmodule : decode_stage_model

// file: verif/tb_top.sv
// Self-checking bench for the exception map
// Assumes a 25 MHz core clock and the decode model on the input side
`timescale 1ns/10ps
module tb_top;
	import fp_exc_map_pkg::*;
	// ==========================================
	// Clock, reset and wiring
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic issue = 1'b0;
	op_class_e iop = OP_NOP;
	logic op_valid_i;
	op_class_e op_class_i;
	logic valid_o;
	logic known_o;
	logic [EXC_W-1:0] exc_allowed_o;
	logic [1:0] round_src_o, src_width_o, dst_width_o, dst_half_o;
	int n_fail = 0;
	int checks = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	decode_stage_model decode_stage_model_inst (.clk_sys_i(clk_sys_i), .issue_i(issue), .issue_op_i(iop),
		.op_valid_o(op_valid_i), .op_class_o(op_class_i));
	dp_vector_fp_exception_map dp_vector_fp_exception_map_inst (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.op_valid_i(op_valid_i),
		.op_class_i(op_class_i),
		.valid_o(valid_o),
		.known_o(known_o),
		.exc_allowed_o(exc_allowed_o),
		.round_src_o(round_src_o),
		.src_width_o(src_width_o),
		.dst_width_o(dst_width_o),
		.dst_half_o(dst_half_o)
	);
	// ==========================================
	// Helpers
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task summarize;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	// Expected {exceptions, rounding source} per class code
	function automatic logic [7:0] expv(input int i);
		case (i)
			1, 11, 12, 13: return {EXC_IP, RND_TRUNC};
			2: return {EXC_NONE, RND_CSR};
			3, 10: return {EXC_IP, RND_CSR};
			4, 5, 18, 19: return {EXC_NO_Z, RND_CSR};
			8, 9, 15, 16, 17: return {EXC_ID, RND_NONE};
			14: return {EXC_ALL, RND_CSR};
			default: return {EXC_NONE, RND_NONE};
		endcase
	endfunction : expv
	task issue1(input op_class_e o);
		@(posedge clk_sys_i);
		issue <= 1'b1;
		iop <= o;
		@(posedge clk_sys_i);
		issue <= 1'b0;
		@(negedge clk_sys_i);
	endtask : issue1
	// ==========================================
	// Scenarios
	// Every class back to back; each answer is looked at while it stands
	task t_sweep;
		logic [7:0] e;
		for (int i = 0; i <= 31; i++) begin
			@(posedge clk_sys_i);
			issue <= (i < 31);
			iop <= op_class_e'(i[4:0]);
			@(negedge clk_sys_i);
			if (i > 0) begin
				e = expv(i - 1);
				chk({valid_o, known_o, exc_allowed_o}, {2'b11, e[7:2]}); // to
				chk({6'h00, round_src_o}, {6'h00, e[1:0]});
			end
		end
	endtask : t_sweep
	task t_shape(input op_class_e o, input logic [5:0] e, input logic [5:0] m);
		issue1(o);
		chk({2'h0, {src_width_o, dst_width_o, dst_half_o} & m}, {2'h0, e & m}); // to
	endtask : t_shape
	task t_shapes;
		t_shape(OP_ALIGNED_VECTOR_MOVE, {WID_128, WID_128, HALF_FULL}, 6'h3f);
		t_shape(OP_UNALIGNED_VECTOR_MOVE, {WID_128, WID_128, HALF_FULL}, 6'h3f);
		t_shape(OP_HIGH_HALF_MOVE, {WID_64, WID_64, HALF_HIGH}, 6'h3f);
		t_shape(OP_LOW_HALF_MOVE, {WID_64, WID_64, HALF_LOW}, 6'h3f);
		t_shape(OP_SCALAR_DOUBLE_MOVE, {WID_64, WID_64, HALF_LOW}, 6'h3f);
		t_shape(OP_SIGN_MASK_EXTRACT, {WID_128, WID_32, HALF_FULL}, 6'h3f);
		t_shape(OP_VECTOR_BITWISE_OR, {WID_128, WID_128, HALF_FULL}, 6'h3f);
		t_shape(OP_VECTOR_BITWISE_XOR, {WID_128, WID_128, HALF_FULL}, 6'h3f);
	endtask : t_shapes
	task t_edge;
		issue1(op_class_e'(5'h1f));
		chk({valid_o, known_o, exc_allowed_o}, {2'b10, EXC_NONE});
		issue1(OP_PACKED_DOUBLE_DIVIDE);
		chk({valid_o, known_o, exc_allowed_o}, {2'b11, EXC_ALL});
		@(negedge clk_sys_i);
		chk({valid_o, known_o, exc_allowed_o}, 8'h00);
	endtask : t_edge
	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_sweep();
		t_shapes();
		t_edge();
		summarize();
	end
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		n_fail++;
		summarize();
	end
endmodule : tb_top
